// File: hw/tpda_top.sv
// Summary of operation
// - Overwrite mode replaces every pixel with the new result each sweep.
// - Average mode keeps a moving power average over 2 to 999 sweeps.
// - Single sweep runs the programmed sweeps then halts; continuous keeps averaging.
// - Max hold keeps the largest level, cleared on change, uses max detector.
// - Min hold keeps the smallest level, cleared on change, uses min detector.
// - Freeze mode leaves the trace untouched; acquisition stops only once every enabled trace is frozen.
// - Each sweep maps onto 711 pixels, each combining all its samples.
// - Dual extreme detector, the default, gives maximum and minimum per pixel.
// - Max detector gives the largest sample of the pixel.
// - Min detector gives the smallest sample of the pixel.
// - Sample detector gives one randomly chosen sample of the pixel.
// - RMS detector gives mean power of all samples in the pixel.
// - Auto detector follows the trace mode table.
// - A manually chosen detector stays whatever the trace mode.
// - Two traces each keep their own mode, detector, math and average count; trace 2 off at reset.
// - Enabling trace 2 makes it active; changes apply to the active trace.
// - Store copies the active trace into a fixed snapshot memory.
// - Math outputs live minus stored or stored minus live, or plain when off.
`timescale 1ns/1ps
`default_nettype none
`include "tpda_consts.svh"

module tpda_fifo #(
	parameter int W = 17,
	parameter int D = 4
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem [0:D-1];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0]   cnt;
	logic          push;
	logic          pop;

	// Full and empty come straight from the fill count.
	assign in_ready = (cnt != (AW+1)'(D));
	assign out_valid = (cnt != '0);
	assign out_data = mem[rp];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Pointers wrap at the depth, so depths that are not powers of two also work.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end
		else
		begin
			if (push)
			begin
				mem[wp] <= in_data;
				wp <= (wp == AW'(D - 1)) ? '0 : wp + 1'b1;
			end
			if (pop)
				rp <= (rp == AW'(D - 1)) ? '0 : rp + 1'b1;
			cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // tpda_fifo

module tpda_top #(
	parameter int FIFO_DEPTH = `TPDA_FIFO_DEPTH
) (
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               in_valid,
	output logic                    in_ready,
	input  wire tpda_pkg::tpda_smp_t in_smp,
	output logic                    acq_on
);
	tpda_pkg::tpda_state_t s;
	tpda_pkg::tpda_state_t next_s;
	logic [31:0] thi [0:1][0:710];
	logic [31:0] tlo [0:1][0:710];
	logic [31:0] mhi [0:1][0:710];
	logic [31:0] mlo [0:1][0:710];
	tpda_pkg::tpda_smp_t f_out;
	logic        f_valid;
	logic        f_ready;
	logic        f_in_ready;
	logic        we;
	logic        cwe;
	logic        wacc;
	logic        map_ok;
	logic [31:0] old_hi;
	logic [31:0] old_lo;
	logic [31:0] rd_lh;
	logic [31:0] rd_ll;
	logic [9:0]  k;
	logic [16:0] dr;
	logic [47:0] sqv;
	tpda_pkg::tpda_tcfg_t c;
	tpda_pkg::tpda_tcfg_t wc;
	tpda_pkg::tpda_det_t  d;

	// Samples queue here; a busy pixel pipeline stalls the drain and thus the source.
	tpda_fifo #(.W(17), .D(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.rst(rst),
		.in_valid(in_valid & s.acq),
		.in_ready(f_in_ready),
		.in_data(in_smp),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_out)
	);

	// The bus answers without wait states; read data was latched in setup.
	assign in_ready = f_in_ready & s.acq;
	assign f_ready = (s.st == tpda_pkg::TPDA_S_RUN) & ~s.store_pend;
	assign pready = 1'b1;
	assign prdata = s.prdata;
	assign acq_on = s.acq;
	assign wacc = psel & penable & pwrite;
	assign map_ok = (paddr[7:5] == 3'b000) & (paddr[1:0] == 2'b00);
	assign pslverr = psel & penable & ~map_ok;
	assign old_hi = thi[s.t][s.pix];
	assign old_lo = tlo[s.t][s.pix];
	assign c = s.cfg[s.t];
	assign k = (s.swc[s.t] < c.avgn) ? s.swc[s.t] + 10'd1 : c.avgn;
	assign dr = {s.drem, s.dnum[47]};
	assign sqv = 48'(f_out.v) * 48'(f_out.v);
	assign we = (s.st == tpda_pkg::TPDA_S_WR) & s.wr;
	assign cwe = (s.st == tpda_pkg::TPDA_S_COPY);

	// Trace arithmetic applied only on the way out, so stored data stays raw.
	always_comb
	begin
		rd_lh = thi[s.act][s.pix_sel];
		rd_ll = tlo[s.act][s.pix_sel];
		case (s.cfg[s.act].math)
			tpda_pkg::TPDA_X_LMM:
			begin
				rd_lh = rd_lh - mhi[s.act][s.pix_sel];
				rd_ll = rd_ll - mlo[s.act][s.pix_sel];
			end
			tpda_pkg::TPDA_X_MML:
			begin
				rd_lh = mhi[s.act][s.pix_sel] - rd_lh;
				rd_ll = mlo[s.act][s.pix_sel] - rd_ll;
			end
			default:
			begin
				rd_lh = thi[s.act][s.pix_sel];
				rd_ll = tlo[s.act][s.pix_sel];
			end
		endcase
	end

	// Auto selection follows the mode table; a manual choice is left alone.
	always_comb
	begin
		d = c.det;
		if (c.auto_det)
		begin
			case (c.mode)
				tpda_pkg::TPDA_M_AVG: d = tpda_pkg::TPDA_D_SAMP;
				tpda_pkg::TPDA_M_MAXH: d = tpda_pkg::TPDA_D_MAX;
				tpda_pkg::TPDA_M_MINH: d = tpda_pkg::TPDA_D_MIN;
				default: d = tpda_pkg::TPDA_D_DUAL;
			endcase
		end
	end

	// Incoming configuration, with the averaging count held inside its legal range.
	always_comb
	begin
		wc = tpda_pkg::tpda_tcfg_t'(pwdata);
		wc.rsv_hi = '0;
		wc.rsv_lo = '0;
		if (wc.avgn < `TPDA_AVG_MIN)
			wc.avgn = `TPDA_AVG_MIN;
		if (wc.avgn > `TPDA_AVG_MAX)
			wc.avgn = `TPDA_AVG_MAX;
		if (wc.det > tpda_pkg::TPDA_D_RMS)
			wc.det = s.cfg[s.act].det;
		if (wc.mode > tpda_pkg::TPDA_M_VIEW)
			wc.mode = s.cfg[s.act].mode;
	end

	// Pixel pipeline, acquisition control and register file in one next-state block.
	always_comb
	begin
		next_s = s;
		next_s.lfsr = {s.lfsr[14:0], s.lfsr[15] ^ s.lfsr[13] ^ s.lfsr[12] ^ s.lfsr[10]};
		case (s.st)
			tpda_pkg::TPDA_S_RUN:
			begin
				if (s.store_pend)
				begin
					next_s.store_pend = 1'b0;
					next_s.idx = '0;
					next_s.st = tpda_pkg::TPDA_S_COPY;
				end
				else if (f_valid)
				begin
					// Every sample of the pixel feeds all detectors at once.
					if (s.cnt == '0 || f_out.v > s.mx)
						next_s.mx = f_out.v;
					if (s.cnt == '0 || f_out.v < s.mn)
						next_s.mn = f_out.v;
					if (s.cnt == '0 || s.lfsr[0])
						next_s.rnd = f_out.v;
					next_s.sq = ((s.cnt == '0) ? 48'h0 : s.sq) + sqv;
					if (s.cnt != 16'hffff)
						next_s.cnt = s.cnt + 16'h1;
					if (f_out.last)
					begin
						next_s.t = 1'b0;
						next_s.st = tpda_pkg::TPDA_S_DET;
					end
				end
			end
			tpda_pkg::TPDA_S_DET:
			begin
				next_s.wr = 1'b1;
				next_s.dual = (d == tpda_pkg::TPDA_D_DUAL);
				next_s.st = tpda_pkg::TPDA_S_CMB;
				if ((s.t && !s.t2_en) || c.mode == tpda_pkg::TPDA_M_VIEW)
				begin
					next_s.wr = 1'b0;
					next_s.st = tpda_pkg::TPDA_S_WR;
				end
				case (d)
					tpda_pkg::TPDA_D_MAX: {next_s.vh, next_s.vl} = {16'h0, s.mx, 16'h0, s.mx};
					tpda_pkg::TPDA_D_MIN: {next_s.vh, next_s.vl} = {16'h0, s.mn, 16'h0, s.mn};
					tpda_pkg::TPDA_D_SAMP: {next_s.vh, next_s.vl} = {16'h0, s.rnd, 16'h0, s.rnd};
					tpda_pkg::TPDA_D_RMS:
					begin
						next_s.dnum = s.sq;
						next_s.dden = s.cnt;
						next_s.drem = '0;
						next_s.di = '0;
						next_s.ph = 2'd0;
						if (next_s.wr)
							next_s.st = tpda_pkg::TPDA_S_DIV;
					end
					default: {next_s.vh, next_s.vl} = {16'h0, s.mx, 16'h0, s.mn};
				endcase
			end
			tpda_pkg::TPDA_S_CMB:
			begin
				next_s.st = tpda_pkg::TPDA_S_WR;
				if (s.swc[s.t] != '0)
				begin
					case (c.mode)
						tpda_pkg::TPDA_M_MAXH:
						begin
							next_s.vh = (old_hi > s.vh) ? old_hi : s.vh;
							next_s.vl = (old_lo > s.vl) ? old_lo : s.vl;
						end
						tpda_pkg::TPDA_M_MINH:
						begin
							next_s.vh = (old_hi < s.vh) ? old_hi : s.vh;
							next_s.vl = (old_lo < s.vl) ? old_lo : s.vl;
						end
						tpda_pkg::TPDA_M_AVG:
						begin
							// Moving average as old plus the difference over the sweep count.
							next_s.sign = s.vh < old_hi;
							next_s.dnum = {16'h0, (s.vh < old_hi) ? old_hi - s.vh : s.vh - old_hi};
							next_s.dden = {6'h0, k};
							next_s.drem = '0;
							next_s.di = '0;
							next_s.ph = 2'd1;
							next_s.st = tpda_pkg::TPDA_S_DIV;
						end
						default: next_s.st = tpda_pkg::TPDA_S_WR;
					endcase
				end
			end
			tpda_pkg::TPDA_S_DIV:
			begin
				// One restoring step per clock; pixel data waits in the queue meanwhile.
				next_s.drem = (dr >= {1'b0, s.dden}) ? 16'(dr - {1'b0, s.dden}) : dr[15:0];
				next_s.dnum = {s.dnum[46:0], dr >= {1'b0, s.dden}};
				next_s.di = s.di + 6'd1;
				if (s.di == `TPDA_DIV_LAST)
				begin
					next_s.drem = '0;
					next_s.di = '0;
					next_s.st = tpda_pkg::TPDA_S_WR;
					case (s.ph)
						2'd0:
						begin
							next_s.vh = (next_s.dnum[47:32] != '0) ? 32'hffffffff : next_s.dnum[31:0];
							next_s.vl = next_s.vh;
							next_s.st = tpda_pkg::TPDA_S_CMB;
						end
						2'd1:
						begin
							next_s.vh = s.sign ? old_hi - next_s.dnum[31:0] : old_hi + next_s.dnum[31:0];
							next_s.vl = next_s.vh;
							if (s.dual)
							begin
								next_s.sign = s.vl < old_lo;
								next_s.dnum = {16'h0, (s.vl < old_lo) ? old_lo - s.vl : s.vl - old_lo};
								next_s.vl = s.vl;
								next_s.ph = 2'd2;
								next_s.st = tpda_pkg::TPDA_S_DIV;
							end
						end
						default:
							next_s.vl = s.sign ? old_lo - next_s.dnum[31:0] : old_lo + next_s.dnum[31:0];
					endcase
				end
			end
			tpda_pkg::TPDA_S_WR:
			begin
				next_s.st = tpda_pkg::TPDA_S_DET;
				next_s.t = 1'b1;
				if (s.t)
				begin
					next_s.st = tpda_pkg::TPDA_S_RUN;
					next_s.cnt = '0;
					next_s.pix = s.pix + 10'd1;
					if (s.pix == `TPDA_PIX_LAST)
					begin
						next_s.pix = '0;
						for (int i = 0; i < 2; i++)
							if ((i == 0 || s.t2_en) && s.cfg[i].mode != tpda_pkg::TPDA_M_VIEW
								&& s.swc[i] < s.cfg[i].avgn)
								next_s.swc[i] = s.swc[i] + 10'd1;
					end
				end
			end
			tpda_pkg::TPDA_S_COPY:
			begin
				next_s.idx = s.idx + 10'd1;
				if (s.idx == `TPDA_PIX_LAST)
					next_s.st = tpda_pkg::TPDA_S_RUN;
			end
			default: next_s.st = tpda_pkg::TPDA_S_RUN;
		endcase
		// Acquisition side: sweeps counted on accepted samples.
		if (in_valid && in_ready && in_smp.last)
		begin
			next_s.in_pix = (s.in_pix == `TPDA_PIX_LAST) ? 10'd0 : s.in_pix + 10'd1;
			if (s.in_pix == `TPDA_PIX_LAST && s.left != '0)
				next_s.left = s.left - 10'd1;
		end
		next_s.acq = ~(s.cfg[0].mode == tpda_pkg::TPDA_M_VIEW
			&& (!s.t2_en || s.cfg[1].mode == tpda_pkg::TPDA_M_VIEW))
			&& (!s.single || next_s.left != '0);
		// Register writes take effect at the access edge.
		if (wacc && map_ok)
		begin
			case (paddr)
				`TPDA_OFS_CTRL:
				begin
					next_s.t2_en = pwdata[`TPDA_CTRL_T2];
					next_s.act = pwdata[`TPDA_CTRL_T2] & pwdata[`TPDA_CTRL_ACT];
					if (pwdata[`TPDA_CTRL_T2] && !s.t2_en)
						next_s.act = 1'b1;
					next_s.single = pwdata[`TPDA_CTRL_SINGLE];
					if (pwdata[`TPDA_CTRL_START])
					begin
						next_s.left = 10'd1;
						if (s.cfg[0].mode == tpda_pkg::TPDA_M_AVG)
							next_s.left = s.cfg[0].avgn;
						else if (s.t2_en && s.cfg[1].mode == tpda_pkg::TPDA_M_AVG)
							next_s.left = s.cfg[1].avgn;
					end
					if (pwdata[`TPDA_CTRL_START] || pwdata[`TPDA_CTRL_CLEAR])
						next_s.swc = '0;
					if (pwdata[`TPDA_CTRL_STORE])
						next_s.store_pend = 1'b1;
				end
				`TPDA_OFS_TCFG:
				begin
					next_s.cfg[s.act] = wc;
					if (wc.mode != s.cfg[s.act].mode)
						next_s.swc[s.act] = '0;
				end
				`TPDA_OFS_PIX: next_s.pix_sel = (pwdata[9:0] > `TPDA_PIX_LAST) ? `TPDA_PIX_LAST
					: pwdata[9:0];
				default: next_s.pix_sel = s.pix_sel;
			endcase
		end
		// Read data is captured in the setup cycle.
		if (psel && !penable)
		begin
			case (paddr)
				`TPDA_OFS_CTRL: next_s.prdata = {29'h0, s.single, s.act, s.t2_en};
				`TPDA_OFS_TCFG: next_s.prdata = 32'(s.cfg[s.act]);
				`TPDA_OFS_STAT: next_s.prdata = {6'h0, s.swc[s.act], 3'h0, s.left,
					s.store_pend, (s.st != tpda_pkg::TPDA_S_RUN) || f_valid, s.acq};
				`TPDA_OFS_PIX: next_s.prdata = {22'h0, s.pix_sel};
				`TPDA_OFS_LHI: next_s.prdata = rd_lh;
				`TPDA_OFS_LLO: next_s.prdata = rd_ll;
				`TPDA_OFS_MHI: next_s.prdata = mhi[s.act][s.pix_sel];
				`TPDA_OFS_MLO: next_s.prdata = mlo[s.act][s.pix_sel];
				default: next_s.prdata = 32'h0;
			endcase
		end
	end

	// State register with a defined reset value for every control field.
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s <= '0;
			s.lfsr <= 16'h0001;
			s.acq <= 1'b1;
			s.cfg[0].auto_det <= 1'b1;
			s.cfg[1].auto_det <= 1'b1;
			s.cfg[0].avgn <= `TPDA_AVG_RST;
			s.cfg[1].avgn <= `TPDA_AVG_RST;
		end
		else
			s <= next_s;
	end

	// Trace and snapshot memories; the snapshot is only touched by a store.
	always_ff @(posedge clk)
	begin
		if (we)
		begin
			thi[s.t][s.pix] <= s.vh;
			tlo[s.t][s.pix] <= s.vl;
		end
		if (cwe)
		begin
			mhi[s.act][s.idx] <= thi[s.act][s.idx];
			mlo[s.act][s.idx] <= tlo[s.act][s.idx];
		end
	end

	sequence store_req;
		wacc && paddr == `TPDA_OFS_CTRL && pwdata[`TPDA_CTRL_STORE];
	endsequence
	sequence copy_run;
		s.st == tpda_pkg::TPDA_S_COPY;
	endsequence
	chk_store_copy: assert property (@(posedge clk) disable iff (rst)
		store_req |-> ##[1:400] copy_run) else $error("store never copied");
	chk_avg_range: assert property (@(posedge clk) disable iff (rst)
		s.cfg[s.act].avgn >= `TPDA_AVG_MIN && s.cfg[s.act].avgn <= `TPDA_AVG_MAX)
		else $error("average count out of range");
	chk_pix_bound: assert property (@(posedge clk) disable iff (rst)
		s.pix <= `TPDA_PIX_LAST) else $error("pixel index past end");
	chk_freeze_hold: assert property (@(posedge clk) disable iff (rst)
		we |-> c.mode != tpda_pkg::TPDA_M_VIEW) else $error("frozen trace written");
	chk_dual_out: assert property (@(posedge clk) disable iff (rst)
		s.st == tpda_pkg::TPDA_S_DET && d == tpda_pkg::TPDA_D_DUAL
		|=> s.vh == {16'h0, $past(s.mx)} && s.vl == {16'h0, $past(s.mn)})
		else $error("dual extreme values wrong");
	chk_auto_max: assert property (@(posedge clk) disable iff (rst)
		s.st == tpda_pkg::TPDA_S_DET && c.auto_det && c.mode == tpda_pkg::TPDA_M_MAXH
		|=> s.vh == {16'h0, $past(s.mx)}) else $error("auto detector not max");
	chk_max_hold: assert property (@(posedge clk) disable iff (rst)
		we && c.mode == tpda_pkg::TPDA_M_MAXH && s.swc[s.t] != '0 |-> s.vh >= old_hi)
		else $error("max hold dropped");
	chk_min_hold: assert property (@(posedge clk) disable iff (rst)
		we && c.mode == tpda_pkg::TPDA_M_MINH && s.swc[s.t] != '0 |-> s.vh <= old_hi)
		else $error("min hold rose");
	chk_t2_active: assert property (@(posedge clk) disable iff (rst)
		wacc && paddr == `TPDA_OFS_CTRL && pwdata[0] && !s.t2_en |=> s.act)
		else $error("trace 2 not active");
	chk_single_halt: assert property (@(posedge clk) disable iff (rst)
		s.single && s.left == '0 && !(wacc && paddr == `TPDA_OFS_CTRL) |=> !s.acq)
		else $error("single sweep not halted");
endmodule // tpda_top
`default_nettype wire

// File: inc/tpda_consts.svh
`ifndef TPDA_CONSTS_SVH
`define TPDA_CONSTS_SVH
// Display geometry and sweep count limits.
`define TPDA_PIX_LAST 10'd710
`define TPDA_AVG_MIN 10'd2
`define TPDA_AVG_MAX 10'd999
`define TPDA_AVG_RST 10'd10
`define TPDA_FIFO_DEPTH 4
// Register byte offsets.
`define TPDA_OFS_CTRL 8'h00
`define TPDA_OFS_TCFG 8'h04
`define TPDA_OFS_STAT 8'h08
`define TPDA_OFS_PIX 8'h0c
`define TPDA_OFS_LHI 8'h10
`define TPDA_OFS_LLO 8'h14
`define TPDA_OFS_MHI 8'h18
`define TPDA_OFS_MLO 8'h1c
// Control register bit positions.
`define TPDA_CTRL_T2 0
`define TPDA_CTRL_ACT 1
`define TPDA_CTRL_SINGLE 2
`define TPDA_CTRL_START 3
`define TPDA_CTRL_CLEAR 4
`define TPDA_CTRL_STORE 5
// Index of the last divider step; the divider runs 48 steps.
`define TPDA_DIV_LAST 6'd47
`endif

// File: inc/tpda_pkg.sv
`include "tpda_consts.svh"
package tpda_pkg;
	typedef enum logic [2:0] {TPDA_M_OVER = 3'b000, TPDA_M_AVG = 3'b001, TPDA_M_MAXH = 3'b010,
		TPDA_M_MINH = 3'b011, TPDA_M_VIEW = 3'b100} tpda_mode_t;
	typedef enum logic [2:0] {TPDA_D_DUAL = 3'b000, TPDA_D_MAX = 3'b001, TPDA_D_MIN = 3'b010,
		TPDA_D_SAMP = 3'b011, TPDA_D_RMS = 3'b100} tpda_det_t;
	typedef enum logic [1:0] {TPDA_X_OFF = 2'b00, TPDA_X_LMM = 2'b01,
		TPDA_X_MML = 2'b10, TPDA_X_RSV = 2'b11} tpda_math_t;
	typedef enum logic [2:0] {TPDA_S_RUN = 3'b000, TPDA_S_DET = 3'b001, TPDA_S_CMB = 3'b010,
		TPDA_S_DIV = 3'b011, TPDA_S_WR = 3'b100, TPDA_S_COPY = 3'b101} tpda_st_t;
	// Layout of the trace configuration register, bit 0 first from the right.
	typedef struct packed {
		logic [5:0] rsv_hi;
		logic [9:0] avgn;
		logic [6:0] rsv_lo;
		tpda_math_t math;
		logic       auto_det;
		tpda_det_t  det;
		tpda_mode_t mode;
	} tpda_tcfg_t;
	typedef struct packed {
		logic        last;
		logic [15:0] v;
	} tpda_smp_t;
	typedef struct packed {
		tpda_st_t              st;
		logic                  t;
		logic [1:0]            ph;
		logic                  wr;
		logic                  dual;
		logic                  sign;
		logic [9:0]            pix;
		logic [15:0]           cnt;
		logic [15:0]           mx;
		logic [15:0]           mn;
		logic [15:0]           rnd;
		logic [47:0]           sq;
		logic [15:0]           lfsr;
		logic [31:0]           vh;
		logic [31:0]           vl;
		logic [47:0]           dnum;
		logic [15:0]           drem;
		logic [15:0]           dden;
		logic [5:0]            di;
		logic [1:0][9:0]       swc;
		tpda_tcfg_t [1:0]      cfg;
		logic                  t2_en;
		logic                  act;
		logic                  single;
		logic [9:0]            left;
		logic                  acq;
		logic [9:0]            in_pix;
		logic [9:0]            pix_sel;
		logic                  store_pend;
		logic [9:0]            idx;
		logic [31:0]           prdata;
	} tpda_state_t;
endpackage

// File: tb/tpda_src.sv
`timescale 1ns/1ps
`default_nettype none

// Stands in for the sweep acquisition path that feeds video samples.
module tpda_src (
	input  wire logic               clk,
	input  wire logic               in_ready,
	output var tpda_pkg::tpda_smp_t in_smp,
	output logic                    in_valid,
	output logic                    hang
);
	// Idle at time zero, and no stuck handshake seen yet.
	initial
	begin
		in_valid = 1'b0;
		in_smp   = '0;
		hang     = 1'b0;
	end

	// Holds one sample until an edge sees ready high; a hang is flagged, not waited out.
	task automatic send(input logic [15:0] v, input logic last);
		int n;
		in_valid <= 1'b1;
		in_smp   <= {last, v};
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (!in_ready && n < 4000 && !hang);
		if (!in_ready)
			hang <= 1'b1;
	endtask

	// A sweep of 711 pixels, two samples each; slow idles between pixels.
	// Released data is inverted so a stale value never looks valid.
	task automatic sweep(input logic [15:0] a, input logic [15:0] b, input logic slow);
		@(posedge clk);
		for (int p = 0; p < 711; p++)
		begin
			send(a + 16'(p), 1'b0);
			send(b + 16'(p), 1'b1);
			if (slow)
			begin
				in_valid <= 1'b0;
				in_smp   <= ~in_smp;
				@(posedge clk);
			end
		end
		in_valid <= 1'b0;
		in_smp   <= ~in_smp;
	endtask
endmodule // tpda_src

`default_nettype wire

// File: tb/trace_pixel_detector_averager_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpda_consts.svh"

module trace_pixel_detector_averager_bench;
	typedef struct packed {
		logic [7:0]  a;
		logic        w;
		logic [31:0] d;
		logic [31:0] e;
	} tpda_row_t;
	logic                clk;
	logic                rst;
	logic                psel;
	logic                penable;
	logic                pwrite;
	logic [7:0]          paddr;
	logic [31:0]         pwdata;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic                in_valid;
	logic                in_ready;
	tpda_pkg::tpda_smp_t in_smp;
	logic                acq_on;
	logic                hang;
	logic [31:0]         rd;
	logic                err;
	int                  error_cnt;
	int                  num_checks;
	tpda_row_t           rows [5];

	tpda_top u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.in_valid(in_valid), .in_ready(in_ready), .in_smp(in_smp), .acq_on(acq_on));
	tpda_src u_src (.clk(clk), .in_ready(in_ready), .in_smp(in_smp), .in_valid(in_valid),
		.hang(hang));

	// Free running 50 MHz clock.
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Counts every comparison and reports a mismatch at once.
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// One APB transfer; the request is held until pready is seen at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (!pready && n < 50);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (!pready)
		begin
			error_cnt++;
			print_verdict();
		end
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string s);
		apb(1'b0, a, 32'h0);
		chk(s, e, rd);
	endtask

	// Selects a pixel, then checks the high and low words at one bank.
	task automatic pix(input logic [31:0] p, input logic [7:0] a, input logic [31:0] eh,
		input logic [31:0] el);
		apb(1'b1, `TPDA_OFS_PIX, p);
		rdc(a, eh, "pixel high");
		rdc(a + 8'h04, el, "pixel low");
	endtask

	// Polls until the pipeline is idle and no store is pending, within a bound.
	task automatic settle();
		int n;
		hang_chk();
		apb(1'b0, `TPDA_OFS_STAT, 32'h0);
		for (n = 0; (rd[1] || rd[2]) && n < 3000; n++)
			apb(1'b0, `TPDA_OFS_STAT, 32'h0);
		if (n >= 3000)
		begin
			error_cnt++;
			print_verdict();
		end
	endtask

	task automatic hang_chk();
		chk("source handshake", 32'h0, {31'h0, hang});
	endtask

	// Main sequence: table rows first, then reset and the awkward cases.
	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		error_cnt = 0;
		num_checks = 0;
		rows = '{'{`TPDA_OFS_TCFG, 1'b1, 32'h03e80001, 32'h03e70001},
			'{`TPDA_OFS_TCFG, 1'b1, 32'h00010001, 32'h00020001},
			'{`TPDA_OFS_TCFG, 1'b1, 32'h000a0005, 32'h000a0001},
			'{`TPDA_OFS_PIX, 1'b1, 32'h000003ff, 32'h000002c6},
			'{`TPDA_OFS_CTRL, 1'b1, 32'h0, 32'h0}};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i])
		begin
			if (rows[i].w)
				apb(1'b1, rows[i].a, rows[i].d);
			rdc(rows[i].a, rows[i].e, "row readback");
		end
		$display("test rows finished");
		// A second reset in mid-run must bring back the default settings.
		@(posedge clk);
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rdc(`TPDA_OFS_CTRL, 32'h0, "ctrl");
		rdc(`TPDA_OFS_TCFG, 32'h000a0040, "tcfg");
		rdc(8'h20, 32'h0, "unmapped");
		chk("pslverr", 32'h1, {31'h0, err});
		$display("test reset finished");
		u_src.sweep(16'h0200, 16'h0000, 1'b0);
		settle();
		pix(32'h0, `TPDA_OFS_LHI, 32'h200, 32'h0);
		pix(32'h3ff, `TPDA_OFS_LHI, 32'h4c6, 32'h2c6);
		apb(1'b1, `TPDA_OFS_CTRL, 32'h20);
		settle();
		apb(1'b1, `TPDA_OFS_TCFG, 32'h000a0042);
		u_src.sweep(16'h0100, 16'h0300, 1'b1);
		settle();
		pix(32'h5, `TPDA_OFS_LHI, 32'h305, 32'h305);
		pix(32'h5, `TPDA_OFS_MHI, 32'h205, 32'h005);
		u_src.sweep(16'h0000, 16'h0100, 1'b0);
		settle();
		pix(32'h5, `TPDA_OFS_LHI, 32'h305, 32'h305);
		$display("test sweeps finished");
		apb(1'b1, `TPDA_OFS_TCFG, 32'h000a00c2);
		pix(32'h5, `TPDA_OFS_LHI, 32'h100, 32'h300);
		apb(1'b1, `TPDA_OFS_TCFG, 32'h000a0142);
		pix(32'h5, `TPDA_OFS_LHI, 32'hffffff00, 32'hfffffd00);
		apb(1'b1, `TPDA_OFS_TCFG, 32'h000a0044);
		repeat (2) @(posedge clk);
		chk("acq_on", 32'h0, {31'h0, acq_on});
		chk("in_ready", 32'h0, {31'h0, in_ready});
		pix(32'h5, `TPDA_OFS_LHI, 32'h305, 32'h305);
		$display("test math and freeze finished");
		apb(1'b1, `TPDA_OFS_CTRL, 32'h1);
		rdc(`TPDA_OFS_CTRL, 32'h3, "ctrl trace two");
		rdc(`TPDA_OFS_TCFG, 32'h000a0040, "tcfg trace two");
		apb(1'b1, `TPDA_OFS_TCFG, 32'h000a0008);
		apb(1'b1, `TPDA_OFS_TCFG, 32'h000a000b);
		rdc(`TPDA_OFS_TCFG, 32'h000a000b, "manual detector");
		repeat (2) @(posedge clk);
		chk("acq_on", 32'h1, {31'h0, acq_on});
		u_src.sweep(16'h0000, 16'h0080, 1'b0);
		settle();
		pix(32'h5, `TPDA_OFS_LHI, 32'h85, 32'h85);
		u_src.sweep(16'h0100, 16'h0000, 1'b0);
		settle();
		pix(32'h5, `TPDA_OFS_LHI, 32'h85, 32'h85);
		apb(1'b1, `TPDA_OFS_CTRL, 32'h1);
		pix(32'h5, `TPDA_OFS_LHI, 32'h305, 32'h305);
		$display("test second trace finished");
		// Trace 2 averages two single sweeps with a manual max detector, then halts.
		apb(1'b1, `TPDA_OFS_CTRL, 32'h3);
		apb(1'b1, `TPDA_OFS_TCFG, 32'h00020009);
		apb(1'b1, `TPDA_OFS_CTRL, 32'hf);
		u_src.sweep(16'h0100, 16'h0200, 1'b0);
		settle();
		u_src.sweep(16'h0300, 16'h0000, 1'b0);
		settle();
		pix(32'h5, `TPDA_OFS_LHI, 32'h285, 32'h285);
		chk("acq_on", 32'h0, {31'h0, acq_on});
		$display("test average finished");
		print_verdict();
	end
endmodule // trace_pixel_detector_averager_bench

`default_nettype wire
